// *** core/cuel_device.sv ***
// Purpose : Event latch and direction logic of the charge counter
// Assumes : Reversal pulses come from logic on clk; pins pass synchronisers
// Notes   : Open-drain lines are modelled as drive-low enables
`timescale 1ns/1ps
module cuel_device
   import cuel_pkg::*;
#(
   parameter int INIT_CYCLES = cuel_pkg::INIT_CYC,  // Initialization length
   parameter int UNIT_STEPS  = cuel_pkg::PRESCALE   // Reversals per unit
) (
   input  wire logic   clk,             // System clock
   input  wire logic   rst_n,           // Synchronous reset, active low
   cuel_if.device_mp   link,            // Pins toward the host
   input  wire logic   reversal_pulse,  // One-cycle integrator reversal
   input  wire logic   reversal_up,     // Reversal direction, high into battery
   output logic        counting,        // Initialization complete
   output logic        lost_event       // One-cycle pulse, unit dropped
);
   import cuel_pkg::*;

   localparam int CW = $clog2(UNIT_STEPS);
   localparam logic [CW-1:0] CNT_MAX = CW'(UNIT_STEPS - 1);
   localparam int WW = $clog2(SELF_WIN_CYC + 1);
   localparam logic [WW-1:0] WIN_LIM = WW'(SELF_WIN_CYC);

   typedef struct packed {
      logic          ack_s1;      // Acknowledge synchroniser, first stage
      logic          ack_s2;      // Acknowledge synchroniser, second stage
      logic          pd_s1;       // Power-down synchroniser, first stage
      logic          pd_s2;       // Power-down synchroniser, second stage
      logic [CW-1:0] count;       // Up/down reversal counter
      logic          pending;     // Event latched
      logic          dir_latched; // Polarity of the latched unit
      logic          live_dir;    // Debounced present polarity
      logic          one_seen;    // One reversal against live polarity
      logic          self_mode;   // Acknowledge follows event line
      logic [WW-1:0] win;         // Cycles since event set
      logic          event_oe;    // Sink event line
      logic          dir_oe;      // Sink direction line
      logic          counting;    // Initialization done
      logic          lost;        // Dropped unit pulse
   } cuel_dev_st_type;

   cuel_dev_st_type st_reg;
   cuel_dev_st_type st_next;

   logic init_done;
   logic ack_done;
   logic hold_done;

   // Initialization runs only while out of power-down
   cuel_timer #(
      .LIMIT (INIT_CYCLES)
   ) u_init_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (st_reg.pd_s2),
      .done  (init_done)
   );

   // Acknowledge low time, counted only while an event waits
   cuel_timer #(
      .LIMIT (CLEAR_CYC)
   ) u_ack_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (st_reg.pending & ~st_reg.ack_s2),
      .done  (ack_done)
   );

   // Least low time of the event line
   cuel_timer #(
      .LIMIT (HOLD_CYC)
   ) u_hold_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (st_reg.pending),
      .done  (hold_done)
   );

   // Next-state logic
   always_comb begin
      logic unit_done;
      logic unit_dir;
      logic clear_now;
      logic shown_dir;
      unit_done = 1'b0;
      unit_dir  = DIR_OUT;
      clear_now = 1'b0;
      shown_dir = DIR_OUT;

      st_next        = st_reg;
      st_next.ack_s1 = link.event_acknowledge_n;
      st_next.ack_s2 = st_reg.ack_s1;
      st_next.pd_s1  = link.power_down_n;
      st_next.pd_s2  = st_reg.pd_s1;
      st_next.lost   = 1'b0;

      if (!st_reg.pd_s2) begin
         // Power-down clears all counting state and floats both lines
         st_next.count       = '0;
         st_next.pending     = 1'b0;
         st_next.dir_latched = DIR_OUT;
         st_next.live_dir    = DIR_OUT;
         st_next.one_seen    = 1'b0;
         st_next.self_mode   = 1'b0;
         st_next.win         = '0;
         st_next.event_oe    = 1'b0;
         st_next.dir_oe      = 1'b0;
         st_next.counting    = 1'b0;
      end else begin
         st_next.counting = init_done;

         // Counter runs regardless of latch or acknowledge state
         if (st_reg.counting && reversal_pulse) begin
            if (reversal_up) begin
               if (st_reg.count == CNT_MAX) begin
                  st_next.count = '0;
                  unit_done     = 1'b1;
                  unit_dir      = DIR_IN;
               end else begin
                  st_next.count = st_reg.count + CW'(1);
               end
            end else begin
               if (st_reg.count == '0) begin
                  st_next.count = CNT_MAX;
                  unit_done     = 1'b1;
                  unit_dir      = DIR_OUT;
               end else begin
                  st_next.count = st_reg.count - CW'(1);
               end
            end
         end

         // A lone reversal against the live polarity is not enough
         if (reversal_pulse) begin
            if (reversal_up != st_reg.live_dir) begin
               if (st_reg.one_seen) begin
                  st_next.live_dir = reversal_up;
                  st_next.one_seen = 1'b0;
               end else begin
                  st_next.one_seen = 1'b1;
               end
            end else begin
               st_next.one_seen = 1'b0;
            end
         end

         // Early acknowledge means the event line drives it
         if (st_reg.win != WIN_LIM) begin
            st_next.win = st_reg.win + WW'(1);
         end
         if (st_reg.pending && !st_reg.ack_s2 && st_reg.win != WIN_LIM) begin
            st_next.self_mode = 1'b1;
         end

         // Host clear needs the full low time; self clear the hold time
         clear_now = st_reg.pending &&
                     (ack_done || ((st_reg.self_mode || st_next.self_mode) &&
                                   hold_done));
         if (clear_now) begin
            st_next.pending   = 1'b0;
            st_next.self_mode = 1'b0;
         end

         // A new unit wins over a clear in the same cycle
         if (unit_done) begin
            if (st_reg.pending && !clear_now) begin
               st_next.lost = 1'b1;
            end else begin
               st_next.pending     = 1'b1;
               st_next.dir_latched = unit_dir;
               st_next.win         = '0;
               st_next.self_mode   = 1'b0;
            end
         end

         // Latched polarity while pending, live polarity otherwise
         shown_dir        = st_next.pending ? st_next.dir_latched
                                            : st_next.live_dir;
         st_next.event_oe = st_next.pending;
         st_next.dir_oe   = (shown_dir == DIR_OUT);
      end
   end

   // State register; sync stages reset to power-down so init restarts
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign link.event_drive = st_reg.event_oe;
   assign link.dir_drive   = st_reg.dir_oe;
   assign counting         = st_reg.counting;
   assign lost_event       = st_reg.lost;
endmodule // cuel_device

// *** core/cuel_pkg.sv ***
// Purpose : Shared constants and types for the charge unit event latch
// Assumes : 40 MHz system clock on both ends
// Notes   : Times kept in printed units, cycle counts derived from them; windows, margins and host delays given in cycles
package cuel_pkg;
   // Clock rate in MHz; the microsecond and millisecond counts below derive from it
   localparam int CLK_MHZ          = 40;
   // Initialization interval after reset or power-down release
   localparam int INIT_US          = 5000;
   localparam int INIT_CYC         = INIT_US * CLK_MHZ;
   // Least acknowledge low time that clears an event
   localparam int CLEAR_US         = 20;
   localparam int CLEAR_CYC        = CLEAR_US * CLK_MHZ;
   // Least low time of a self-cleared event
   localparam int HOLD_US          = 1;
   localparam int HOLD_CYC         = HOLD_US * CLK_MHZ;
   // Reversals per charge unit and reversals needed to show a new polarity
   localparam int PRESCALE         = 1024;
   localparam int POL_REVERSALS    = 2;
   // Acknowledge falling this soon after an event counts as wired back
   localparam int SELF_WIN_CYC     = 4;
   // Host service deadline and shortest spacing of charge units
   localparam int ACK_DEADLINE_MS  = 500;
   localparam int ACK_DEADLINE_CYC = ACK_DEADLINE_MS * 1000 * CLK_MHZ;
   localparam int MIN_INTERVAL_MS  = 596;
   localparam int MIN_INTERVAL_CYC = MIN_INTERVAL_MS * 1000 * CLK_MHZ;
   // Host acknowledge pulse: least clear time plus synchroniser margin
   localparam int SYNC_MARGIN_CYC  = 8;
   localparam int HOST_PULSE_CYC   = CLEAR_CYC + SYNC_MARGIN_CYC;
   localparam int HOST_SERVICE_CYC = 16;
   localparam int HOST_SETTLE_CYC  = 4;
   // Direction encoding on the direction line
   localparam logic DIR_IN         = 1'b1;
   localparam logic DIR_OUT        = 1'b0;

   // Host servicing states
   typedef enum logic [1:0] {
      HST_IDLE   = 2'b00,
      HST_WAIT   = 2'b01,
      HST_PULSE  = 2'b10,
      HST_SETTLE = 2'b11
   } cuel_host_state_type;
endpackage : cuel_pkg

// *** core/cuel_if.sv ***
// Purpose : Pin bundle between the charge unit device and its host
// Assumes : Open-drain event and direction lines with pull-ups
// Notes   : self_clear is set by the bench to wire event back to clear
`timescale 1ns/1ps
interface cuel_if;
   logic event_drive;          // Device pulls event line low
   logic dir_drive;            // Device pulls direction line low
   logic host_ack_n;           // Host acknowledge, active low
   logic power_down_n;         // Host power-down, active low
   logic self_clear;           // Event wired back to acknowledge
   logic charge_event_n;       // Resolved event line
   logic current_direction;    // Resolved direction line
   logic event_acknowledge_n;  // Acknowledge seen by device

   // Pull-ups win unless the device sinks the line
   assign charge_event_n      = ~event_drive;
   assign current_direction   = ~dir_drive;
   assign event_acknowledge_n = self_clear ? charge_event_n : host_ack_n;

   modport device_mp (
      input  event_acknowledge_n,
      input  power_down_n,
      output event_drive,
      output dir_drive
   );
   modport host_mp (
      input  charge_event_n,
      input  current_direction,
      output host_ack_n,
      output power_down_n
   );
endinterface : cuel_if

// *** core/cuel_timer.sv ***
// Purpose : Saturating run-length timer
// Assumes : run is synchronous to clk
// Notes   : done stays high while run holds after LIMIT cycles
`timescale 1ns/1ps
module cuel_timer #(
   parameter int LIMIT = 4,
   parameter int W     = $clog2(LIMIT + 1)
) (
   input  wire logic clk,    // System clock
   input  wire logic rst_n,  // Synchronous reset, active low
   input  wire logic run,    // Count while high, clear when low
   output logic      done    // Run has lasted LIMIT cycles
);
   import cuel_pkg::*;

   typedef struct packed {
      logic [W-1:0] count;
   } cuel_timer_st_type;

   localparam logic [W-1:0] LIM = W'(LIMIT);

   cuel_timer_st_type st_reg;
   cuel_timer_st_type st_next;

   // Saturate so a long run cannot wrap into a false done
   always_comb begin
      st_next = st_reg;
      if (!run) begin
         st_next.count = '0;
      end else if (st_reg.count != LIM) begin
         st_next.count = st_reg.count + W'(1);
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign done = (st_reg.count == LIM);
endmodule // cuel_timer

// *** core/cuel_host.sv ***
// Purpose : Host end that services charge events
// Assumes : Event and direction lines are asynchronous to clk
// Notes   : Splits events into charge-in and charge-out pulses
`timescale 1ns/1ps
module cuel_host
   import cuel_pkg::*;
#(
   parameter int DEADLINE_CYCLES = cuel_pkg::ACK_DEADLINE_CYC, // Service limit
   parameter int SERVICE_CYCLES  = cuel_pkg::HOST_SERVICE_CYC, // Response delay
   parameter int PULSE_CYCLES    = cuel_pkg::HOST_PULSE_CYC    // Ack low time
) (
   input  wire logic   clk,              // System clock
   input  wire logic   rst_n,            // Synchronous reset, active low
   cuel_if.host_mp     link,             // Pins toward the device
   input  wire logic   shutdown_req,     // Request device power-down
   input  wire logic   battery_present,  // Lines valid only while high
   output logic        charge_in_pulse,  // One-cycle pulse, unit into battery
   output logic        charge_out_pulse, // One-cycle pulse, unit out of battery
   output logic        deadline_missed   // Sticky, service too slow
);
   import cuel_pkg::*;

   typedef struct packed {
      logic                ev_s1;   // Event synchroniser, first stage
      logic                ev_s2;   // Event synchroniser, second stage
      logic                dir_s1;  // Direction synchroniser, first stage
      logic                dir_s2;  // Direction synchroniser, second stage
      cuel_host_state_type state;   // Servicing state
      logic                ack_n;   // Acknowledge pin level
      logic                pd_n;    // Power-down pin level
      logic                in_p;    // Charge-in pulse
      logic                out_p;   // Charge-out pulse
      logic                late;    // Deadline missed
   } cuel_host_st_type;

   cuel_host_st_type st_reg;
   cuel_host_st_type st_next;

   logic service_done;
   logic pulse_done;
   logic settle_done;
   logic deadline_done;

   // Response delay before reading the lines
   cuel_timer #(
      .LIMIT (SERVICE_CYCLES)
   ) u_service_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (st_reg.state == HST_WAIT),
      .done  (service_done)
   );

   // Acknowledge pulse length, margin covers the device synchroniser
   cuel_timer #(
      .LIMIT (PULSE_CYCLES)
   ) u_pulse_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (st_reg.state == HST_PULSE),
      .done  (pulse_done)
   );

   // Let the released event line settle through the synchroniser
   cuel_timer #(
      .LIMIT (HOST_SETTLE_CYC)
   ) u_settle_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (st_reg.state == HST_SETTLE),
      .done  (settle_done)
   );

   // Service time from event seen to acknowledge released
   cuel_timer #(
      .LIMIT (DEADLINE_CYCLES)
   ) u_deadline_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   ((st_reg.state == HST_WAIT) || (st_reg.state == HST_PULSE)),
      .done  (deadline_done)
   );

   // Next-state logic
   always_comb begin
      st_next        = st_reg;
      st_next.ev_s1  = link.charge_event_n;
      st_next.ev_s2  = st_reg.ev_s1;
      st_next.dir_s1 = link.current_direction;
      st_next.dir_s2 = st_reg.dir_s1;
      st_next.pd_n   = ~shutdown_req;
      st_next.in_p   = 1'b0;
      st_next.out_p  = 1'b0;
      if (deadline_done) begin
         st_next.late = 1'b1;
      end

      unique case (st_reg.state)
         HST_IDLE: begin
            if (battery_present && st_reg.pd_n && !st_reg.ev_s2) begin
               st_next.state = HST_WAIT;
            end
         end
         HST_WAIT: begin
            if (service_done) begin
               // Direction is latched while the event stays low
               st_next.in_p  = (st_reg.dir_s2 == DIR_IN);
               st_next.out_p = (st_reg.dir_s2 == DIR_OUT);
               st_next.ack_n = 1'b0;
               st_next.state = HST_PULSE;
            end
         end
         HST_PULSE: begin
            if (pulse_done) begin
               st_next.ack_n = 1'b1;
               st_next.state = HST_SETTLE;
            end
         end
         HST_SETTLE: begin
            if (settle_done) begin
               st_next.state = HST_IDLE;
            end
         end
      endcase

      // Lines are meaningless without a battery or in power-down
      if (!battery_present || !st_reg.pd_n) begin
         st_next.state = HST_IDLE;
         st_next.ack_n = 1'b1;
         st_next.in_p  = 1'b0;
         st_next.out_p = 1'b0;
      end
   end

   // State register; pins idle inactive, device held in power-down
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg       <= '0;
         st_reg.ack_n <= 1'b1;
         st_reg.ev_s1 <= 1'b1;
         st_reg.ev_s2 <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign link.host_ack_n   = st_reg.ack_n;
   assign link.power_down_n = st_reg.pd_n;
   assign charge_in_pulse   = st_reg.in_p;
   assign charge_out_pulse  = st_reg.out_p;
   assign deadline_missed   = st_reg.late;
endmodule // cuel_host

// *** tb/cuel_monitor.sv ***
// Purpose : Timing assertions on the lines between device and host
// Assumes : Host pulse and self-clear timings from the shared package
// Notes   : Helper run-length counters stand in for long repetitions
`timescale 1ns/1ps
module cuel_monitor (
   input wire logic clk,                 // System clock
   input wire logic rst_n,               // Synchronous reset, active low
   input wire logic event_drive,         // Device sinks event line
   input wire logic dir_drive,           // Device sinks direction line
   input wire logic host_ack_n,          // Host acknowledge
   input wire logic power_down_n,        // Power-down, active low
   input wire logic self_clear,          // Event wired back to acknowledge
   input wire logic charge_event_n,      // Resolved event line
   input wire logic current_direction,   // Resolved direction line
   input wire logic event_acknowledge_n  // Acknowledge seen by device
);
   import cuel_pkg::*;
   localparam int ACK_LIM = CLEAR_CYC + 6;
   logic [10:0] ack_cnt_reg;
   logic [7:0]  hi_cnt_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Run lengths of acknowledge low and event drive high, saturating
   always_ff @(posedge clk) begin
      if (!rst_n || host_ack_n) ack_cnt_reg <= 11'h000;
      else if (ack_cnt_reg < 11'(ACK_LIM)) ack_cnt_reg <= ack_cnt_reg + 11'h001;
      if (!rst_n || !event_drive) hi_cnt_reg <= 8'h00;
      else if (hi_cnt_reg != 8'hFF) hi_cnt_reg <= hi_cnt_reg + 8'h01;
   end

   property p_reset_idle;
      $rose(rst_n) |-> !event_drive && !dir_drive && host_ack_n && !power_down_n;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("lines not idle after reset");
   property p_pd_float;
      !power_down_n [*4] |-> !event_drive && !dir_drive;
   endproperty
   a_pd_float: assert property (p_pd_float)
      else $error("lines driven in power-down");
   property p_event_held;
      (event_acknowledge_n && power_down_n) [*4] ##0 event_drive |=> event_drive;
   endproperty
   a_event_held: assert property (p_event_held)
      else $error("event dropped without acknowledge");
   property p_dir_latched;
      event_drive && $past(event_drive) && $past(event_acknowledge_n)
         && $past(event_acknowledge_n, 2) && $past(event_acknowledge_n, 3) |-> $stable(dir_drive);
   endproperty
   a_dir_latched: assert property (p_dir_latched)
      else $error("direction moved while event pending");
   property p_clear_min;
      $fell(event_drive) && !self_clear && power_down_n |-> ack_cnt_reg >= 11'(CLEAR_CYC);
   endproperty
   a_clear_min: assert property (p_clear_min)
      else $error("event cleared by short acknowledge");
   property p_clear_bound;
      ack_cnt_reg == 11'(ACK_LIM) && !self_clear && power_down_n |-> !event_drive;
   endproperty
   a_clear_bound: assert property (p_clear_bound)
      else $error("long acknowledge did not clear event");
   property p_self_width;
      $fell(event_drive) && self_clear |-> hi_cnt_reg >= 8'(HOLD_CYC)
         && hi_cnt_reg <= 8'(HOLD_CYC + 8);
   endproperty
   a_self_width: assert property (p_self_width)
      else $error("self-cleared pulse width off");
   property p_self_release;
      $rose(event_drive) && self_clear |-> ##[1:60] !event_drive;
   endproperty
   a_self_release: assert property (p_self_release)
      else $error("self-cleared event never released");
   property p_ack_on_event;
      $fell(host_ack_n) |-> !charge_event_n && power_down_n;
   endproperty
   a_ack_on_event: assert property (p_ack_on_event)
      else $error("host acknowledged with no event");
   property p_host_pulse;
      $rose(host_ack_n) && power_down_n |-> ack_cnt_reg >= 11'(CLEAR_CYC);
   endproperty
   a_host_pulse: assert property (p_host_pulse)
      else $error("host acknowledge pulse too short");
endmodule // cuel_monitor

// *** tb/tb.sv ***
// Purpose : Self-checking bench joining device and host ends
// Assumes : Shortened init interval and charge unit size
// Notes   : Host clears events except in s_self, where the event is wired back to clear; bench feeds reversals
`timescale 1ns/1ps
`define CHK(name, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
   $display("unexpected %s: expected %0h seen %0h", name, exp, got); end end
module tb;
   import cuel_pkg::*;
   localparam int INIT_T = 50;
   localparam int UNIT   = 8;
   localparam int LIMIT  = 30000;
   logic clk, rst_n, rev_pulse, rev_up, shutdown_req, battery_present;
   logic counting, lost_event, in_pulse, out_pulse, deadline_missed;
   int   error_cnt, tests_run, cyc_cnt, lost_n, in_n, out_n;
   cuel_if bus ();
   cuel_device #(.INIT_CYCLES(INIT_T), .UNIT_STEPS(UNIT)) u_cuel_device (
      .clk(clk), .rst_n(rst_n), .link(bus.device_mp), .reversal_pulse(rev_pulse),
      .reversal_up(rev_up), .counting(counting), .lost_event(lost_event));
   cuel_host #(.DEADLINE_CYCLES(2000)) u_cuel_host (
      .clk(clk), .rst_n(rst_n), .link(bus.host_mp), .shutdown_req(shutdown_req),
      .battery_present(battery_present), .charge_in_pulse(in_pulse),
      .charge_out_pulse(out_pulse), .deadline_missed(deadline_missed));
   cuel_monitor u_cuel_monitor (
      .clk(clk), .rst_n(rst_n), .event_drive(bus.event_drive), .dir_drive(bus.dir_drive),
      .host_ack_n(bus.host_ack_n), .power_down_n(bus.power_down_n),
      .self_clear(bus.self_clear), .charge_event_n(bus.charge_event_n),
      .current_direction(bus.current_direction),
      .event_acknowledge_n(bus.event_acknowledge_n));

   // Clock of 25 ns
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // Tally one-cycle outputs; cut a hang short
   always @(posedge clk) begin
      cyc_cnt++;
      if (lost_event === 1'b1) lost_n++;
      if (in_pulse === 1'b1) in_n++;
      if (out_pulse === 1'b1) out_n++;
      if (cyc_cnt == LIMIT) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Back-to-back reversals, then two cycles for the latch to land
   task automatic rev(input logic up, input int n);
      @(negedge clk);
      rev_up = up;
      rev_pulse = 1'b1;
      repeat (n) @(negedge clk);
      rev_pulse = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic wait_ev(input logic lvl, input int lim);
      int k;
      k = 0;
      while (bus.charge_event_n !== lvl && k < lim) begin
         @(negedge clk);
         k++;
      end
      `CHK("event line", lvl, bus.charge_event_n)
      // Host holds acknowledge a few cycles past the clear; a unit landing
      // then would be taken as wired-back mode, so let it settle first
      repeat (10) @(negedge clk);
   endtask

   task automatic s_unit;
      rev(1'b1, UNIT - 1);
      `CHK("event early", 1'b1, bus.charge_event_n)
      rev(1'b1, 1);
      `CHK("event set", 1'b0, bus.charge_event_n)
      `CHK("dir latched", DIR_IN, bus.current_direction)
      wait_ev(1'b1, 1200);
      `CHK("dir live", DIR_IN, bus.current_direction)
      `CHK("in count", 1, in_n)
   endtask

   task automatic s_lost;
      rev(1'b1, 2 * UNIT);
      `CHK("lost count", 1, lost_n)
      wait_ev(1'b1, 1200);
      `CHK("in count", 2, in_n)
   endtask

   // Half a unit counted while acknowledge is low must not vanish
   task automatic s_ack;
      rev(1'b1, UNIT);
      repeat (40) @(negedge clk);
      `CHK("ack low", 1'b0, bus.host_ack_n)
      rev(1'b1, UNIT / 2);
      wait_ev(1'b1, 1200);
      rev(1'b1, UNIT / 2);
      `CHK("event kept count", 1'b0, bus.charge_event_n)
      wait_ev(1'b1, 1200);
      `CHK("in count", 4, in_n)
   endtask

   task automatic s_down;
      rev(1'b0, 1);
      `CHK("underflow event", 1'b0, bus.charge_event_n)
      `CHK("dir out latched", DIR_OUT, bus.current_direction)
      wait_ev(1'b1, 1200);
      `CHK("dir one reversal", DIR_IN, bus.current_direction)
      rev(1'b0, 1);
      `CHK("dir two reversals", DIR_OUT, bus.current_direction)
      `CHK("no event", 1'b1, bus.charge_event_n)
      `CHK("out count", 1, out_n)
   endtask

   task automatic s_self;
      int w;
      bus.self_clear = 1'b1;
      rev(1'b0, UNIT - 2);
      `CHK("no event", 1'b1, bus.charge_event_n)
      rev(1'b0, 1);
      w = 2;
      while (bus.charge_event_n === 1'b0 && w < 200) begin
         @(negedge clk);
         w++;
      end
      `CHK("self width", 1'b1, w >= HOLD_CYC && w <= HOLD_CYC + 8)
      repeat (900) @(negedge clk);
      bus.self_clear = 1'b0;
      `CHK("out count", 2, out_n)
   endtask

   task automatic s_pd;
      int k;
      shutdown_req = 1'b1;
      repeat (6) @(negedge clk);
      `CHK("counting", 1'b0, counting)
      `CHK("dir float", 1'b1, bus.current_direction)
      rev(1'b1, UNIT);
      `CHK("no event", 1'b1, bus.charge_event_n)
      shutdown_req = 1'b0;
      k = 0;
      while (counting !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      `CHK("init wait", 1'b1, k >= INIT_T && k < INIT_T + 10)
      `CHK("dir restart", DIR_OUT, bus.current_direction)
   endtask

   task automatic s_batt;
      battery_present = 1'b0;
      rev(1'b1, UNIT);
      repeat (100) @(negedge clk);
      `CHK("event held", 1'b0, bus.charge_event_n)
      `CHK("in count", 4, in_n)
      battery_present = 1'b1;
      wait_ev(1'b1, 1200);
      `CHK("in count", 5, in_n)
      `CHK("deadline", 1'b0, deadline_missed)
   endtask

   initial begin
      rst_n = 1'b0;
      rev_pulse = 1'b0;
      rev_up = 1'b0;
      shutdown_req = 1'b0;
      battery_present = 1'b1;
      bus.self_clear = 1'b0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (INIT_T + 10) @(negedge clk);
      `CHK("counting", 1'b1, counting)
      s_unit();
      s_lost();
      s_ack();
      s_down();
      s_self();
      s_pd();
      s_batt();
      close_out();
   end
endmodule // tb
